/* File: core/rx_err_stat_cfg.svh */
`ifndef RX_ERR_STAT_CFG_SVH
`define RX_ERR_STAT_CFG_SVH

// register offsets, byte addresses
`define OFS_RX_DMA_OVERRUN      8'h00
`define OFS_RX_SYMBOL_ERROR     8'h04
`define OFS_OVERSIZE_CLEAN      8'h08
`define OFS_OVERSIZE_BAD        8'h0C
`define OFS_UNDERSIZE_CLEAN     8'h10
`define OFS_MISSING_HEARTBEAT   8'h14
`define OFS_LENGTH_MISMATCH     8'h18
`define OFS_NET_CONFIG          8'h20
`define OFS_IRQ_STATUS          8'h24
`define OFS_IRQ_MASK            8'h28

// counter indices, also interrupt bit positions
`define IDX_RX_DMA_OVERRUN      0
`define IDX_RX_SYMBOL_ERROR     1
`define IDX_OVERSIZE_CLEAN      2
`define IDX_OVERSIZE_BAD        3
`define IDX_UNDERSIZE_CLEAN     4
`define IDX_MISSING_HEARTBEAT   5
`define IDX_LENGTH_MISMATCH     6
`define NUM_COUNTERS            7

// network configuration fields
`define CFG_SPEED_100_BIT       0
`define CFG_HALF_DUPLEX_BIT     4
`define CFG_BIG_FRAME_BIT       8
`define CFG_LEN_CHECK_BIT       16
`define CFG_RESET               32'h0000_0000

// other reset values
`define CNT_RESET               8'h00
`define IRQ_RESET               7'h00

// frame length limits in bytes
`define MIN_FRAME_LEN           14'h0040
`define MAX_FRAME_LEN           14'h05EE
`define MAX_BIG_FRAME_LEN       14'h0600
`define TYPE_ID_MIN             16'h0600
`define FRAME_OVERHEAD          17'h00012

// heartbeat window: 96 bit times at each link speed
`define CLK_PERIOD_NS           10
`define SQE_WINDOW_100_NS       960
`define SQE_WINDOW_10_NS        9600

`endif

/* File: core/rx_err_stat_pkg.sv */
package rx_err_stat_pkg;

	// per-frame summary from the receive path, valid with done
	typedef struct packed {
		logic        done;      // one-cycle end-of-frame strobe
		logic        addr_ok;   // frame passed address recognition
		logic        dma_ovr;   // receive dma overran on this frame
		logic        crc_bad;   // crc check failed
		logic        odd_bits;  // not an integral number of bytes
		logic [13:0] byte_len;  // measured length in bytes
		logic [15:0] len_type;  // length/type field, bytes 13 and 14
	} rx_frame_type;

	// register port request
	typedef struct packed {
		logic        wr;        // write strobe
		logic        rd;        // read strobe
		logic [7:0]  addr;      // byte address
		logic [31:0] wdata;     // write data
	} reg_req_type;

	// heartbeat watch states
	typedef enum logic [0:0] {
		SQE_IDLE,
		SQE_WAIT
	} sqe_state_type;

endpackage

/* File: core/sat_counter.sv */
`timescale 1ns/1ps
`include "rx_err_stat_cfg.svh"

module sat_counter #(
	parameter int W = 8
) (
	// clock and control
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	// count and load
	input  wire logic         inc_i,
	input  wire logic         wr_i,
	input  wire logic [W-1:0] wdata_i,
	output logic      [W-1:0] count_o
);

	logic [W-1:0] count_r;   // current count
	logic [W-1:0] count_nxt; // next count
	logic         at_max;    // all ones, hold there

	assign at_max    = &count_r;
	// software load wins, otherwise saturating increment
	assign count_nxt = wr_i ? wdata_i :
	                   (inc_i && !at_max) ? count_r + {{(W-1){1'b0}}, 1'b1} : count_r;

	// counter register, cleared on reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_r <= '0;
		end else if (ce_i) begin
			count_r <= count_nxt;
		end
	end

	assign count_o = count_r;

endmodule

/* File: core/rx_err_stat.sv */
// Contract
// - count address-matched frames lost to dma overrun
// - count frames with receive error asserted
// - valid-length symbol error also flags fcs/alignment
// - oversize symbol error counts as jabber instead
// - count oversize frames with no errors
// - count oversize frames with any error
// - count short frames with no errors
// - count missing collision after transmit, half duplex
// - count frames shorter than their length field
// - length check only when enable bit set
// - skip type frames and oversize for mismatch
// - transmit underrun frame bumps no other counter
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "rx_err_stat_cfg.svh"

module rx_err_stat
	import rx_err_stat_pkg::*;
#(
	parameter int CNT_W = 8
) (
	// clock, reset, enable
	input  wire logic         CORE_CLK_I,
	input  wire logic         SRST_I,
	input  wire logic         CE_I,
	// register port
	input  wire reg_req_type  REG_REQ_I,
	output logic      [31:0]  REG_RDATA_O,
	// receive path summary
	input  wire rx_frame_type RX_FRAME_I,
	// phy pins, asynchronous
	input  wire logic         MII_RX_DV_I,
	input  wire logic         MII_RX_ER_I,
	input  wire logic         MII_COL_I,
	// transmit path, same clock
	input  wire logic         TX_EN_I,
	input  wire logic         TX_UNDERRUN_I,
	// error pulses toward fcs/alignment counters
	output logic              FCS_ERR_O,
	output logic              ALIGN_ERR_O,
	// interrupt
	output logic              IRQ_O
);

	localparam int NC = `NUM_COUNTERS;

	// heartbeat window lengths in clock cycles, rounded down, never below one
	localparam int SQE_CYC_100_RAW = `SQE_WINDOW_100_NS / `CLK_PERIOD_NS;
	localparam int SQE_CYC_10_RAW  = `SQE_WINDOW_10_NS / `CLK_PERIOD_NS;
	localparam int SQE_CYC_100     = (SQE_CYC_100_RAW < 1) ? 1 : SQE_CYC_100_RAW;
	localparam int SQE_CYC_10      = (SQE_CYC_10_RAW < 1) ? 1 : SQE_CYC_10_RAW;
	localparam logic [10:0] SQE_LOAD_100 = 11'(SQE_CYC_100);
	localparam logic [10:0] SQE_LOAD_10  = 11'(SQE_CYC_10);

	// one-hot counter select from a byte address
	function automatic logic [NC-1:0] cnt_sel(input logic [7:0] addr);
		logic [NC-1:0] sel;
		sel = '0;
		case (addr)
			`OFS_RX_DMA_OVERRUN:    sel[`IDX_RX_DMA_OVERRUN]    = 1'b1;
			`OFS_RX_SYMBOL_ERROR:   sel[`IDX_RX_SYMBOL_ERROR]   = 1'b1;
			`OFS_OVERSIZE_CLEAN:    sel[`IDX_OVERSIZE_CLEAN]    = 1'b1;
			`OFS_OVERSIZE_BAD:      sel[`IDX_OVERSIZE_BAD]      = 1'b1;
			`OFS_UNDERSIZE_CLEAN:   sel[`IDX_UNDERSIZE_CLEAN]   = 1'b1;
			`OFS_MISSING_HEARTBEAT: sel[`IDX_MISSING_HEARTBEAT] = 1'b1;
			`OFS_LENGTH_MISMATCH:   sel[`IDX_LENGTH_MISMATCH]   = 1'b1;
			default:                sel = '0;
		endcase
		return sel;
	endfunction

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [2:0] pin_meta_r;   // first stage, read only by second stage
	logic [2:0] pin_sync_r;   // second stage
	logic       rx_dv_s;      // synced receive data valid
	logic       rx_er_s;      // synced receive error
	logic       col_s;        // synced collision

	// two flops on every phy pin
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			pin_meta_r <= 3'h0;
			pin_sync_r <= 3'h0;
		end else if (CE_I) begin
			pin_meta_r <= {MII_COL_I, MII_RX_ER_I, MII_RX_DV_I};
			pin_sync_r <= pin_meta_r;
		end
	end

	assign rx_dv_s = pin_sync_r[0];
	assign rx_er_s = pin_sync_r[1];
	assign col_s   = pin_sync_r[2];

	// ---------------------------------------------------------------
	// configuration register
	// ---------------------------------------------------------------
	logic [31:0] cfg_r;       // network configuration
	logic        big_frame;   // 1536-byte limit selected
	logic        len_check;   // length field checking on
	logic        half_duplex; // half duplex operation
	logic        speed_100;   // 100 Mb/s link

	assign big_frame   = cfg_r[`CFG_BIG_FRAME_BIT];
	assign len_check   = cfg_r[`CFG_LEN_CHECK_BIT];
	assign half_duplex = cfg_r[`CFG_HALF_DUPLEX_BIT];
	assign speed_100   = cfg_r[`CFG_SPEED_100_BIT];

	// register port decode
	logic          wr_cfg;    // config write
	logic          wr_isr;    // status write-one-to-clear
	logic          wr_imr;    // mask write
	logic [NC-1:0] wr_cnt;    // counter loads

	assign wr_cfg = REG_REQ_I.wr && (REG_REQ_I.addr == `OFS_NET_CONFIG);
	assign wr_isr = REG_REQ_I.wr && (REG_REQ_I.addr == `OFS_IRQ_STATUS);
	assign wr_imr = REG_REQ_I.wr && (REG_REQ_I.addr == `OFS_IRQ_MASK);
	assign wr_cnt = REG_REQ_I.wr ? cnt_sel(REG_REQ_I.addr) : '0;

	// config storage
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			cfg_r <= `CFG_RESET;
		end else if (CE_I && wr_cfg) begin
			cfg_r <= REG_REQ_I.wdata;
		end
	end

	// ---------------------------------------------------------------
	// receive symbol error capture over one frame
	// ---------------------------------------------------------------
	logic sym_seen_r;   // rx error seen since last frame end
	logic sym_err;      // symbol error for the closing frame

	// sticky while frame runs, restarts after each frame end
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			sym_seen_r <= 1'b0;
		end else if (CE_I) begin
			if (RX_FRAME_I.done) begin
				sym_seen_r <= 1'b0;
			end else if (rx_dv_s && rx_er_s) begin
				sym_seen_r <= 1'b1;
			end
		end
	end

	// an error on the last cycle still belongs to this frame
	assign sym_err = sym_seen_r || (rx_dv_s && rx_er_s);

	// ---------------------------------------------------------------
	// receive classification
	// ---------------------------------------------------------------
	logic [13:0] max_len;     // current oversize threshold
	logic        done;        // frame closes this cycle
	logic        any_err;     // crc or symbol error
	logic        oversize;    // longer than maximum
	logic        undersize;   // shorter than minimum
	logic        valid_len;   // between minimum and maximum
	logic        is_length;   // field is a length, not a type
	logic [16:0] need_len;    // field plus header and crc
	logic        short_field; // measured below field

	assign max_len   = big_frame ? `MAX_BIG_FRAME_LEN : `MAX_FRAME_LEN;
	assign done      = RX_FRAME_I.done;
	assign any_err   = RX_FRAME_I.crc_bad || sym_err;
	assign oversize  = RX_FRAME_I.byte_len > max_len;
	assign undersize = RX_FRAME_I.byte_len < `MIN_FRAME_LEN;
	assign valid_len = !undersize && !oversize;
	assign is_length = RX_FRAME_I.len_type < `TYPE_ID_MIN;
	assign need_len  = {1'b0, RX_FRAME_I.len_type} + `FRAME_OVERHEAD;
	assign short_field = {3'h0, RX_FRAME_I.byte_len} < need_len;

	// per-counter increment terms
	logic [NC-1:0] inc;        // increments this cycle
	logic          sqe_miss;   // heartbeat not seen in window

	assign inc[`IDX_RX_DMA_OVERRUN]    = done && RX_FRAME_I.addr_ok
	                                     && RX_FRAME_I.dma_ovr;
	assign inc[`IDX_RX_SYMBOL_ERROR]   = done && sym_err;
	assign inc[`IDX_OVERSIZE_CLEAN]    = done && oversize && !any_err;
	assign inc[`IDX_OVERSIZE_BAD]      = done && oversize && any_err;
	assign inc[`IDX_UNDERSIZE_CLEAN]   = done && undersize && !any_err;
	assign inc[`IDX_MISSING_HEARTBEAT] = sqe_miss;
	assign inc[`IDX_LENGTH_MISMATCH]   = done && len_check && is_length
	                                     && !oversize && short_field;

	// fcs/alignment flags, valid length only
	logic fcs_nxt;     // integral bytes, bad crc or symbol error
	logic align_nxt;   // odd bits, bad crc or symbol error

	assign fcs_nxt   = done && any_err && valid_len && !RX_FRAME_I.odd_bits;
	assign align_nxt = done && any_err && valid_len && RX_FRAME_I.odd_bits;

	// registered error pulses
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			FCS_ERR_O   <= 1'b0;
			ALIGN_ERR_O <= 1'b0;
		end else if (CE_I) begin
			FCS_ERR_O   <= fcs_nxt;
			ALIGN_ERR_O <= align_nxt;
		end
	end

	// ---------------------------------------------------------------
	// heartbeat (sqe test) watch after transmit
	// ---------------------------------------------------------------
	sqe_state_type sqe_state_r;  // watch state
	logic [10:0]   sqe_cnt_r;    // cycles left in window
	logic          tx_en_q_r;    // transmit enable last cycle
	logic          tx_under_r;   // underrun seen in current frame
	logic          tx_fall;      // transmit just ended
	logic          tx_rise;      // transmit just started

	assign tx_fall = tx_en_q_r && !TX_EN_I;
	assign tx_rise = !tx_en_q_r && TX_EN_I;

	// track transmit edges and underrun per frame
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			tx_en_q_r  <= 1'b0;
			tx_under_r <= 1'b0;
		end else if (CE_I) begin
			tx_en_q_r <= TX_EN_I;
			if (tx_rise) begin
				tx_under_r <= TX_UNDERRUN_I;
			end else if (TX_UNDERRUN_I) begin
				tx_under_r <= 1'b1;
			end
		end
	end

	// window timer and state
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			sqe_state_r <= SQE_IDLE;
			sqe_cnt_r   <= 11'h000;
		end else if (CE_I) begin
			case (sqe_state_r)
				SQE_IDLE: begin
					// underrun frames are left out of the watch
					if (tx_fall && half_duplex && !tx_under_r && !TX_UNDERRUN_I) begin
						sqe_state_r <= SQE_WAIT;
						sqe_cnt_r   <= speed_100 ? SQE_LOAD_100 : SQE_LOAD_10;
					end
				end
				SQE_WAIT: begin
					// collision seen or new frame: watch ends quietly
					if (col_s || TX_EN_I) begin
						sqe_state_r <= SQE_IDLE;
					end else if (sqe_cnt_r == 11'h001) begin
						sqe_state_r <= SQE_IDLE;
					end else begin
						sqe_cnt_r <= sqe_cnt_r - 11'h001;
					end
				end
				default: begin
					sqe_state_r <= SQE_IDLE;
				end
			endcase
		end
	end

	// window ran out with no collision
	assign sqe_miss = (sqe_state_r == SQE_WAIT) && !col_s && !TX_EN_I
	                  && (sqe_cnt_r == 11'h001);

	// ---------------------------------------------------------------
	// counters, each updated on its own
	// ---------------------------------------------------------------
	logic [CNT_W-1:0] cnt_val [NC];   // counter values

	genvar g;
	generate
		for (g = 0; g < NC; g++) begin : g_cnt
			sat_counter #(
				.W       (CNT_W)
			) u_cnt (
				.clk_i   (CORE_CLK_I),
				.rst_i   (SRST_I),
				.ce_i    (CE_I),
				.inc_i   (inc[g]),
				.wr_i    (wr_cnt[g]),
				.wdata_i (REG_REQ_I.wdata[CNT_W-1:0]),
				.count_o (cnt_val[g])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// interrupt status and mask
	// ---------------------------------------------------------------
	logic [NC-1:0] isr_r;     // sticky event bits
	logic [NC-1:0] imr_r;     // enable mask
	logic [NC-1:0] isr_nxt;   // next status

	// set wins over a write-one clear in the same cycle
	assign isr_nxt = (isr_r & ~(wr_isr ? REG_REQ_I.wdata[NC-1:0] : '0)) | inc;

	// status, mask and interrupt line
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			isr_r <= `IRQ_RESET;
			imr_r <= `IRQ_RESET;
			IRQ_O <= 1'b0;
		end else if (CE_I) begin
			isr_r <= isr_nxt;
			if (wr_imr) begin
				imr_r <= REG_REQ_I.wdata[NC-1:0];
			end
			IRQ_O <= |(isr_nxt & (wr_imr ? REG_REQ_I.wdata[NC-1:0] : imr_r));
		end
	end

	// ---------------------------------------------------------------
	// read path, data one cycle after the strobe
	// ---------------------------------------------------------------
	logic [NC-1:0]    rd_sel;     // counter selected for read
	logic [CNT_W-1:0] rd_cnt;     // selected counter value
	logic [31:0]      rd_mux;     // read data before the flop

	assign rd_sel = cnt_sel(REG_REQ_I.addr);

	// or together the selected counter
	always_comb begin
		rd_cnt = '0;
		for (int i = 0; i < NC; i++) begin
			if (rd_sel[i]) begin
				rd_cnt = rd_cnt | cnt_val[i];
			end
		end
	end

	// map the remaining registers, unmapped reads as zero
	always_comb begin
		if (|rd_sel) begin
			rd_mux = {{(32-CNT_W){1'b0}}, rd_cnt};
		end else if (REG_REQ_I.addr == `OFS_NET_CONFIG) begin
			rd_mux = cfg_r;
		end else if (REG_REQ_I.addr == `OFS_IRQ_STATUS) begin
			rd_mux = {{(32-NC){1'b0}}, isr_r};
		end else if (REG_REQ_I.addr == `OFS_IRQ_MASK) begin
			rd_mux = {{(32-NC){1'b0}}, imr_r};
		end else begin
			rd_mux = 32'h0000_0000;
		end
	end

	// read data stands only in the cycle after the read strobe
	always_ff @(posedge CORE_CLK_I) begin
		if (SRST_I) begin
			REG_RDATA_O <= 32'h0000_0000;
		end else if (CE_I) begin
			REG_RDATA_O <= REG_REQ_I.rd ? rd_mux : 32'h0000_0000;
		end
	end

endmodule

/* File: dv/rx_err_stat_properties.sv */
`timescale 1ns/1ps
`include "rx_err_stat_cfg.svh"

module rx_err_stat_properties
	import rx_err_stat_pkg::*;
#(
	parameter int CNT_W = 8
) (
	// clock, reset, enable
	input  wire logic         CORE_CLK_I,
	input  wire logic         SRST_I,
	input  wire logic         CE_I,
	// register port
	input  wire reg_req_type  REG_REQ_I,
	input  wire logic [31:0]  REG_RDATA_O,
	// frame summary and results
	input  wire rx_frame_type RX_FRAME_I,
	input  wire logic         FCS_ERR_O,
	input  wire logic         ALIGN_ERR_O,
	input  wire logic         IRQ_O
);
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (SRST_I);

	wire logic [13:0] len_w = RX_FRAME_I.byte_len;      // measured length
	wire logic        tk_w  = RX_FRAME_I.done && CE_I;  // frame taken
	wire logic        rd_w  = REG_REQ_I.rd && CE_I;     // read taken

	// bad crc inside the valid length band
	sequence s_err_in_range;
		tk_w && RX_FRAME_I.crc_bad && len_w >= `MIN_FRAME_LEN && len_w <= `MAX_FRAME_LEN;
	endsequence
	// frame beyond even the extended limit
	sequence s_oversize;
		tk_w && len_w > `MAX_BIG_FRAME_LEN;
	endsequence

	a_fcs_on_crc: assert property (s_err_in_range ##0 !RX_FRAME_I.odd_bits |=> FCS_ERR_O)
		else $error("fcs pulse missing");
	a_align_on_odd: assert property (s_err_in_range ##0 RX_FRAME_I.odd_bits
		|=> ALIGN_ERR_O && !FCS_ERR_O) else $error("align pulse missing");
	a_oversize_no_fcs: assert property (s_oversize |=> !FCS_ERR_O && !ALIGN_ERR_O)
		else $error("oversize frame flagged fcs");
	a_short_no_fcs: assert property (tk_w && len_w < `MIN_FRAME_LEN
		|=> !FCS_ERR_O && !ALIGN_ERR_O) else $error("short frame flagged fcs");
	a_fcs_has_cause: assert property ((FCS_ERR_O || ALIGN_ERR_O)
		|-> $past(tk_w) && $past(len_w) >= `MIN_FRAME_LEN) else $error("stray error pulse");
	a_rdata_idle: assert property (!$past(rd_w) |-> REG_RDATA_O == 32'h0)
		else $error("read data outside its cycle");
	a_rdata_narrow: assert property (rd_w && REG_REQ_I.addr != `OFS_NET_CONFIG
		|=> REG_RDATA_O[31:8] == 24'h0) else $error("upper read bits set");
	a_rd_unmapped: assert property (rd_w && REG_REQ_I.addr == 8'h1C
		|=> REG_RDATA_O == 32'h0) else $error("unmapped read not zero");
	a_irq_masked: assert property (REG_REQ_I.wr && CE_I && REG_REQ_I.addr == `OFS_IRQ_MASK
		&& REG_REQ_I.wdata[6:0] == 7'h00 |-> ##2 !IRQ_O) else $error("irq with mask clear");
endmodule

bind rx_err_stat rx_err_stat_properties #(.CNT_W(CNT_W)) rx_err_stat_properties_i (
	.CORE_CLK_I  (CORE_CLK_I),
	.SRST_I      (SRST_I),
	.CE_I        (CE_I),
	.REG_REQ_I   (REG_REQ_I),
	.REG_RDATA_O (REG_RDATA_O),
	.RX_FRAME_I  (RX_FRAME_I),
	.FCS_ERR_O   (FCS_ERR_O),
	.ALIGN_ERR_O (ALIGN_ERR_O),
	.IRQ_O       (IRQ_O)
);

/* File: dv/phy_model.sv */
`timescale 1ns/1ps

module phy_model (
	// clock and bench control
	input  wire logic       clk_i,
	input  wire logic       rx_go_i,
	input  wire logic       rx_bad_i,
	input  wire logic       tx_en_i,
	input  wire logic [9:0] col_wait_i,
	// mii pins toward the mac
	output logic            rx_dv_o,
	output logic            rx_er_o,
	output logic            col_o
);
	int   since_r = 0;     // cycles since tx enable fell
	logic tx_en_r = 1'b0;  // tx enable one cycle ago

	// receive pins follow the frame envelope, idle low
	assign rx_dv_o = rx_go_i;
	assign rx_er_o = rx_go_i & rx_bad_i;
	// heartbeat answer, zero wait means none
	assign col_o = col_wait_i != 10'h0 && since_r >= int'(col_wait_i)
		&& since_r < int'(col_wait_i) + 2;

	// time since end of transmit
	always_ff @(posedge clk_i) begin
		tx_en_r <= tx_en_i;
		if (tx_en_r && !tx_en_i) begin
			since_r <= 1;
		end else if (since_r != 0 && since_r < 1000) begin
			since_r <= since_r + 1;
		end
	end
endmodule

/* File: dv/test_rx_err_stat.sv */
`timescale 1ns/1ps
`include "rx_err_stat_cfg.svh"

module test_rx_err_stat
	import rx_err_stat_pkg::*;
;
	logic         clk = 1'b0;    // core clock
	logic         rst = 1'b1;    // synchronous reset
	reg_req_type  req = '0;      // register request
	logic [31:0]  rdata;         // read data
	rx_frame_type rxf = '0;      // frame summary
	logic         dv, er, col;   // phy pins
	logic         txen = 1'b0;   // transmit enable
	logic         ce = 1'b1;     // clock enable
	logic         tx_underrun_field = 1'b0;   // transmit underrun
	logic         fcs, aln, irq; // results
	logic         go = 1'b0;     // receive envelope
	logic         bad = 1'b0;    // receive error request
	logic [9:0]   cw = 10'h0;    // heartbeat delay
	logic [31:0]  cfg = 32'h0;   // expected configuration
	logic [7:0]   exp_cnt [7] = '{default: 8'h00}; // expected counters
	int           error_cnt = 0;
	int           total_checks = 0;

	// clock source
	initial begin
		forever #5 clk = ~clk;
	end

	rx_err_stat rx_err_stat_i (.CORE_CLK_I(clk), .SRST_I(rst), .CE_I(ce),
		.REG_REQ_I(req), .REG_RDATA_O(rdata), .RX_FRAME_I(rxf), .MII_RX_DV_I(dv),
		.MII_RX_ER_I(er), .MII_COL_I(col), .TX_EN_I(txen), .TX_UNDERRUN_I(tx_underrun_field),
		.FCS_ERR_O(fcs), .ALIGN_ERR_O(aln), .IRQ_O(irq));
	phy_model phy_model_i (.clk_i(clk), .rx_go_i(go), .rx_bad_i(bad), .tx_en_i(txen),
		.col_wait_i(cw), .rx_dv_o(dv), .rx_er_o(er), .col_o(col));

	// compare and count
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		total_checks++;
		if (got !== ex) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		req <= '0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ex);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clk);
		req <= '0;
		#1 chk($sformatf("reg %h", a), ex, rdata);
	endtask

	// all counters against expectation
	task automatic chk_all();
		for (int i = 0; i < 7; i++) rd(8'(i * 4), {24'h0, exp_cnt[i]});
	endtask

	task automatic set_cfg(input logic [31:0] d);
		cfg = d;
		wr(`OFS_NET_CONFIG, d);
	endtask

	// one received frame, flags are crc, sym, odd, addr ok, dma overrun
	task automatic frm(input logic [13:0] len, input logic [4:0] f, input logic [15:0] lt);
		logic       ov, un, e;
		logic [8:0] m;
		ov = len > (cfg[`CFG_BIG_FRAME_BIT] ? `MAX_BIG_FRAME_LEN : `MAX_FRAME_LEN);
		un = len < `MIN_FRAME_LEN;
		e = f[4] | f[3];
		m = {e & !un & !ov & f[2], e & !un & !ov & !f[2], cfg[`CFG_LEN_CHECK_BIT]
			& (lt < `TYPE_ID_MIN) & !ov & ({3'h0, len} < {1'b0, lt} + `FRAME_OVERHEAD),
			1'b0, un & !e, ov & e, ov & !e, f[3], f[1] & f[0]};
		@(posedge clk);
		go <= 1'b1;
		bad <= f[3];
		@(posedge clk);
		bad <= 1'b0;
		repeat (3) @(posedge clk);
		rxf <= {1'b1, f[1], f[0], f[4], f[2], len, lt};
		@(posedge clk);
		rxf <= '0;
		go <= 1'b0;
		#1 chk("fcs pulse", 32'(m[7]), 32'(fcs));
		chk("align pulse", 32'(m[8]), 32'(aln));
		for (int i = 0; i < 7; i++) if (m[i] && exp_cnt[i] != 8'hFF) exp_cnt[i]++;
		chk_all();
	endtask

	// one transmit frame, then the heartbeat window runs out
	task automatic hb(input logic und, input logic [9:0] w, input logic inc);
		cw <= w;
		@(posedge clk);
		txen <= 1'b1;
		tx_underrun_field <= und;
		repeat (8) @(posedge clk);
		txen <= 1'b0;
		tx_underrun_field <= 1'b0;
		repeat (1000) @(posedge clk);
		if (inc) exp_cnt[5]++;
		chk_all();
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		tally_and_finish();
	end

	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		chk_all();
		rd(8'h1C, 32'h0);
		wr(`OFS_OVERSIZE_BAD, 32'hFFFF_FFFE);
		exp_cnt[3] = 8'hFE;
		// a load while the enable is low must not land
		ce <= 1'b0;
		wr(`OFS_UNDERSIZE_CLEAN, 32'h0000_0055);
		ce <= 1'b1;
		rd(`OFS_UNDERSIZE_CLEAN, 32'h0);
		$display("test reset and load done");
		frm(14'h05EF, 5'b10000, 16'h0);
		frm(14'h0640, 5'b01000, 16'h0);
		frm(14'h0640, 5'b00000, 16'h0);
		frm(14'h05EE, 5'b00000, 16'h0);
		frm(14'h0064, 5'b01000, 16'h0);
		frm(14'h0064, 5'b01100, 16'h0);
		frm(14'h0064, 5'b10100, 16'h0);
		frm(14'h0040, 5'b10000, 16'h0);
		frm(14'h003F, 5'b00000, 16'h0);
		frm(14'h003F, 5'b10000, 16'h0);
		frm(14'h0064, 5'b00011, 16'h0);
		frm(14'h0064, 5'b00001, 16'h0);
		frm(14'h0040, 5'b00000, 16'h002F);
		set_cfg(32'h0001_0100);
		frm(14'h0600, 5'b00000, 16'h0);
		frm(14'h0601, 5'b01000, 16'h0);
		frm(14'h0600, 5'b01000, 16'h0);
		frm(14'h0040, 5'b00000, 16'h002F);
		frm(14'h0040, 5'b00000, 16'h002E);
		frm(14'h0040, 5'b00000, 16'h0600);
		frm(14'h0700, 5'b00000, 16'h05FF);
		$display("test receive classes done");
		chk("irq masked", 32'h0, 32'(irq));
		rd(`OFS_IRQ_STATUS, 32'h0000_005F);
		wr(`OFS_IRQ_MASK, 32'h0000_0004);
		@(posedge clk);
		#1 chk("irq raised", 32'h1, 32'(irq));
		wr(`OFS_IRQ_STATUS, 32'h0000_007F);
		@(posedge clk);
		#1 chk("irq cleared", 32'h0, 32'(irq));
		rd(`OFS_IRQ_STATUS, 32'h0);
		wr(`OFS_IRQ_MASK, 32'h0);
		$display("test interrupt done");
		set_cfg(32'h0000_0001);
		hb(1'b0, 10'h000, 1'b0);
		set_cfg(32'h0000_0011);
		hb(1'b0, 10'h000, 1'b1);
		hb(1'b0, 10'h014, 1'b0);
		hb(1'b0, 10'h096, 1'b1);
		hb(1'b1, 10'h000, 1'b0);
		set_cfg(32'h0000_0010);
		hb(1'b0, 10'h1F4, 1'b0);
		hb(1'b0, 10'h000, 1'b1);
		$display("test heartbeat done");
		tally_and_finish();
	end
endmodule
